// file: src/rti_params.svh
`ifndef RTI_PARAMS_SVH
`define RTI_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (word index; byte address is four times the index)
// ----------------------------------------------------------------
`define RTI_IDX_CFG 6'h1d
`define RTI_IDX_STAT 6'h20
`define RTI_CFG_RESET 16'h0000

// ----------------------------------------------------------------
// Field positions inside the insertion config register
// ----------------------------------------------------------------
`define RTI_CSUM_SEL_BIT 15
`define RTI_SEC_EN_BIT 14
`define RTI_SEC_LEN_HI 13
`define RTI_SEC_LEN_LO 12
`define RTI_NS_OFF_HI 11
`define RTI_NS_OFF_LO 6
`define RTI_SEC_OFF_HI 5
`define RTI_SEC_OFF_LO 0

// ----------------------------------------------------------------
// Datapath constants
// ----------------------------------------------------------------
`define RTI_NS_BYTES 3'h4
`define RTI_NS_SPAN 8'h04
`define RTI_CORR_ERR 16'h0001
`define RTI_CNT_MAX 8'hff
`define RTI_ZERO_BYTE 8'h00

`endif

// file: src/rti_pkg.sv
package rti_pkg;

    // Position of the current byte relative to the PTP message
    typedef enum logic [1:0] {
        phase_idle,
        phase_in_msg,
        phase_after
    } rti_phase_t;

endpackage : rti_pkg

// file: src/rti_byte_pick.sv
`timescale 1ns/1ps

// Picks one byte of a field written MSB first over a window of positions
module rti_byte_pick (
    input wire logic [31:0] value_in,
    input wire logic [2:0] nbytes_in,
    input wire logic [7:0] offset_in,
    input wire logic [7:0] index_in,
    output logic hit_out,
    output logic [7:0] byte_out
);
    // ----------------------------------------------------------------
    // Window test and byte select
    // ----------------------------------------------------------------
    wire logic [8:0] end_pos = {1'b0, offset_in} + {6'h00, nbytes_in};
    wire logic [7:0] rel = index_in - offset_in;
    wire logic [2:0] shift_bytes = nbytes_in - 3'h1 - rel[2:0];
    wire logic [31:0] shifted = value_in >> {shift_bytes, 3'h0};

    // Window closed on the top so wrap past 255 never matches
    assign hit_out = (index_in >= offset_in) && ({1'b0, index_in} < end_pos);
    assign byte_out = shifted[7:0];
endmodule : rti_byte_pick

// file: src/rti_rx_insertion_enable.sv
`timescale 1ns/1ps
`include "rti_params.svh"

// Contract
// - Checksum handling acts only on IPv4 PTP event frames and only while insertion is enabled.
// - With checksum correction off, the UDP checksum of each stamped IPv4 event frame is zeroed.
// - With checksum correction off and a bad incoming UDP checksum, the frame CRC is corrupted.
// - With checksum correction on, the checksum is kept and a two-byte fix follows the PTP message.
// - With checksum correction on and a bad incoming checksum, the fix is made to leave it bad.
// - Seconds bytes are inserted only while seconds insertion is enabled; otherwise nanoseconds only.
// - Seconds enable, seconds length and both offsets have no effect while insertion is disabled.
// - The seconds length field 00..11 selects one to four least significant seconds bytes.
// - Seconds length is ignored when insertion or seconds insertion is off.
// - In append placement the nanoseconds offset counts from the end of the PTP message.
// - In in-place placement both offsets count from the first byte of the PTP message.
// - In append placement the seconds offset counts from the end of the inserted nanoseconds.
// - While insertion is enabled the captured timestamp is not offered for readout.
// - Append placement applies to Layer 2 frames only and only while insertion is enabled.
module rti_rx_insertion_enable (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_last_in,
    input wire logic msg_start_in,
    input wire logic msg_end_in,
    input wire logic udp_csum_byte_in,
    input wire logic fcs_byte_in,
    input wire logic ptp_event_in,
    input wire logic ipv4_in,
    input wire logic layer2_in,
    input wire logic udp_csum_err_in,
    input wire logic ts_valid_in,
    input wire logic [31:0] ts_ns_in,
    input wire logic [31:0] ts_sec_in,
    output logic mac_valid_out,
    output logic [7:0] mac_data_out,
    output logic mac_last_out,
    output logic ts_readout_valid_out
);
    // ----------------------------------------------------------------
    // Register bus slave
    // ----------------------------------------------------------------
    logic [15:0] rx_timestamp_insert_config;
    logic [15:0] insertion_enable_word;
    logic [15:0] frames_done;
    logic bus_ack;

    // One wait state: request is answered on the edge after it is seen
    wire logic bus_req = avs_read_in | avs_write_in;
    wire logic hit_cfg = avs_address_in[7:2] == `RTI_IDX_CFG;
    wire logic hit_stat = avs_address_in[7:2] == `RTI_IDX_STAT;
    wire logic cfg_wr = avs_write_in & bus_ack & hit_cfg;
    wire logic [15:0] next_cfg = {avs_byteenable_in[1] ? avs_writedata_in[15:8] : rx_timestamp_insert_config[15:8],
                                  avs_byteenable_in[0] ? avs_writedata_in[7:0] : rx_timestamp_insert_config[7:0]};
    wire logic [31:0] next_readdata = hit_cfg ? {16'h0000, rx_timestamp_insert_config} :
                                      hit_stat ? {16'h0000, frames_done} : 32'h0000_0000;
    assign avs_waitrequest_out = bus_req & ~bus_ack;

    // Ack and read data; unmapped reads return zero, unmapped writes vanish
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_ack <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
            if (avs_read_in & ~bus_ack) begin
                avs_readdata_out <= next_readdata;
            end
        end
    end

    // Config register write with byte lanes
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_timestamp_insert_config <= `RTI_CFG_RESET;
        end else if (cfg_wr) begin
            rx_timestamp_insert_config <= next_cfg;
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    // Insertion and append bits live in byte lane 2 of the config address,
    // outside the 16-bit config register; they are held in a local word
    // register here, loaded from the same bus write path.
    wire logic insertion_enable = insertion_enable_word[0];
    wire logic append_placement = insertion_enable_word[1];
    wire logic checksum_correction_select = rx_timestamp_insert_config[`RTI_CSUM_SEL_BIT];
    wire logic seconds_insert_enable = rx_timestamp_insert_config[`RTI_SEC_EN_BIT];
    wire logic [1:0] seconds_insert_length = rx_timestamp_insert_config[`RTI_SEC_LEN_HI:`RTI_SEC_LEN_LO];
    wire logic [5:0] nanosec_field_offset = rx_timestamp_insert_config[`RTI_NS_OFF_HI:`RTI_NS_OFF_LO];
    wire logic [5:0] sec_field_offset = rx_timestamp_insert_config[`RTI_SEC_OFF_HI:`RTI_SEC_OFF_LO];

    // Control word at byte lane 2 of the config address; lane 3 is not stored
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            insertion_enable_word <= `RTI_CFG_RESET;
        end else if (cfg_wr && avs_byteenable_in[2]) begin
            insertion_enable_word <= {8'h00, avs_writedata_in[23:16]};
        end
    end

    // ----------------------------------------------------------------
    // Timestamp capture for the frame in flight
    // ----------------------------------------------------------------
    logic [31:0] ts_ns_q;
    logic [31:0] ts_sec_q;
    logic ts_have;

    // A new capture in the last byte's cycle wins over the clear
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ts_ns_q <= 32'h0000_0000;
            ts_sec_q <= 32'h0000_0000;
            ts_have <= 1'b0;
        end else if (ts_valid_in) begin
            ts_ns_q <= ts_ns_in;
            ts_sec_q <= ts_sec_in;
            ts_have <= 1'b1;
        end else if (rx_valid_in & rx_last_in) begin
            ts_have <= 1'b0;
        end
    end

    // Readout is offered only when the stamp is not being inserted
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ts_readout_valid_out <= 1'b0;
        end else begin
            ts_readout_valid_out <= ts_valid_in & ~insertion_enable;
        end
    end

    // ----------------------------------------------------------------
    // Message position tracking
    // ----------------------------------------------------------------
    rti_pkg::rti_phase_t phase;
    rti_pkg::rti_phase_t next_phase;
    logic [7:0] pos;
    logic [7:0] after_cnt;

    wire logic in_msg_now = msg_start_in | (phase == rti_pkg::phase_in_msg);
    wire logic after_now = phase == rti_pkg::phase_after;
    wire logic [7:0] cur_pos = msg_start_in ? 8'h00 : pos;

    // Next phase; the frame end always returns to idle
    always_comb begin
        next_phase = phase;
        unique case (phase)
            rti_pkg::phase_idle: begin
                if (msg_start_in & msg_end_in) begin
                    next_phase = rti_pkg::phase_after;
                end else if (msg_start_in) begin
                    next_phase = rti_pkg::phase_in_msg;
                end
            end
            rti_pkg::phase_in_msg: begin
                if (msg_end_in) begin
                    next_phase = rti_pkg::phase_after;
                end
            end
            rti_pkg::phase_after: begin
                next_phase = rti_pkg::phase_after;
            end
        endcase
        if (rx_last_in) begin
            next_phase = rti_pkg::phase_idle;
        end
    end

    // Counters advance only on forwarded bytes
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase <= rti_pkg::phase_idle;
            pos <= 8'h00;
            after_cnt <= 8'h00;
        end else if (rx_valid_in) begin
            phase <= next_phase;
            pos <= cur_pos + 8'h01;
            if (in_msg_now & msg_end_in) begin
                after_cnt <= 8'h00;
            end else if (after_now && after_cnt != `RTI_CNT_MAX) begin
                after_cnt <= after_cnt + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Insertion placement
    // ----------------------------------------------------------------
    // Every effect below hangs off ins_frame, so a disabled block passes bytes untouched
    wire logic ins_frame = insertion_enable & ptp_event_in & ts_have;
    wire logic append_mode = append_placement & layer2_in & insertion_enable;
    wire logic [7:0] idx = append_mode ? after_cnt : cur_pos;
    wire logic region_ok = append_mode ? after_now : in_msg_now;
    wire logic [7:0] ns_off8 = {2'b00, nanosec_field_offset};
    // Appended seconds start past the four nanosecond bytes
    wire logic [7:0] sec_off8 = append_mode ? ns_off8 + `RTI_NS_SPAN + {2'b00, sec_field_offset}
                                            : {2'b00, sec_field_offset};
    wire logic [2:0] sec_nbytes = {1'b0, seconds_insert_length} + 3'h1;
    wire logic ns_hit;
    wire logic sec_hit;
    wire logic [7:0] ns_byte;
    wire logic [7:0] sec_byte;

    rti_byte_pick u_ns_pick (
        .value_in(ts_ns_q),
        .nbytes_in(`RTI_NS_BYTES),
        .offset_in(ns_off8),
        .index_in(idx),
        .hit_out(ns_hit),
        .byte_out(ns_byte)
    );

    rti_byte_pick u_sec_pick (
        .value_in(ts_sec_q),
        .nbytes_in(sec_nbytes),
        .offset_in(sec_off8),
        .index_in(idx),
        .hit_out(sec_hit),
        .byte_out(sec_byte)
    );

    // Nanoseconds win if a careless offset overlaps the two fields
    wire logic ins_ns = ins_frame & region_ok & ns_hit;
    wire logic ins_sec = ins_frame & region_ok & seconds_insert_enable & sec_hit & ~ins_ns;

    // ----------------------------------------------------------------
    // UDP checksum handling
    // ----------------------------------------------------------------
    // Append is Layer 2 only, so every timestamp write in a UDP frame is in place inside the message
    wire logic csum_apply = ins_frame & ipv4_in & ~layer2_in;
    wire logic zero_csum = csum_apply & ~checksum_correction_select & udp_csum_byte_in;
    wire logic fcs_bad = csum_apply & ~checksum_correction_select & udp_csum_err_in & fcs_byte_in;
    // Relies on software enabling correction only with two spare bytes present
    wire logic corr_hi = csum_apply & checksum_correction_select & after_now & (after_cnt == 8'h00);
    wire logic corr_lo = csum_apply & checksum_correction_select & after_now & (after_cnt == 8'h01);
    wire logic ins_any = ins_ns | ins_sec;
    wire logic [7:0] new_byte = ins_ns ? ns_byte : sec_byte;
    // Message starts on an even UDP offset, so even positions are word high bytes
    wire logic word_hi = ~idx[0];
    wire logic [19:0] old_term = word_hi ? {4'h0, rx_data_in, 8'h00} : {12'h000, rx_data_in};
    wire logic [19:0] new_term = word_hi ? {4'h0, new_byte, 8'h00} : {12'h000, new_byte};
    logic [19:0] acc_old;
    logic [19:0] acc_new;

    // End-around carry fold to 16 bits
    function automatic logic [15:0] rti_fold(input logic [19:0] s);
        logic [16:0] t;
        t = {1'b0, s[15:0]} + {13'h0000, s[19:16]};
        return t[15:0] + {15'h0000, t[16]};
    endfunction : rti_fold

    // Fix word = sum(old) - sum(new) in ones' complement
    wire logic [15:0] fold_old = rti_fold(acc_old);
    wire logic [15:0] fold_new_inv = ~rti_fold(acc_new);
    wire logic [16:0] corr_sum = {1'b0, fold_old} + {1'b0, fold_new_inv};
    wire logic [15:0] corr_good = corr_sum[15:0] + {15'h0000, corr_sum[16]};
    wire logic [15:0] corr_word = udp_csum_err_in ? corr_good ^ `RTI_CORR_ERR : corr_good;

    // Accumulate the replaced and replacing words of this message
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_old <= 20'h0_0000;
            acc_new <= 20'h0_0000;
        end else if (rx_valid_in & msg_start_in) begin
            acc_old <= ins_any ? old_term : 20'h0_0000;
            acc_new <= ins_any ? new_term : 20'h0_0000;
        end else if (rx_valid_in & ins_any & ~append_mode) begin
            acc_old <= acc_old + old_term;
            acc_new <= acc_new + new_term;
        end
    end

    // ----------------------------------------------------------------
    // Output byte select and pipeline register
    // ----------------------------------------------------------------
    wire logic [7:0] next_data = fcs_bad ? ~rx_data_in :
                                 zero_csum ? `RTI_ZERO_BYTE :
                                 corr_hi ? corr_word[15:8] :
                                 corr_lo ? corr_word[7:0] :
                                 ins_any ? new_byte :
                                 rx_data_in;

    // One cycle of latency; data always from flops
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mac_valid_out <= 1'b0;
            mac_data_out <= 8'h00;
            mac_last_out <= 1'b0;
        end else begin
            mac_valid_out <= rx_valid_in;
            mac_last_out <= rx_valid_in & rx_last_in;
            if (rx_valid_in) begin
                mac_data_out <= next_data;
            end
        end
    end

    // Count of stamped frames, visible in the status register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frames_done <= 16'h0000;
        end else if (rx_valid_in & rx_last_in & ins_frame) begin
            frames_done <= frames_done + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_bus_one_wait: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        bus_req && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer took more than one wait cycle");

    a_ipv4_only: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && udp_csum_byte_in && !ipv4_in && !ins_any && !fcs_byte_in
        |=> mac_data_out == $past(rx_data_in))
        else $error("checksum touched on a non IPv4 frame");

    a_csum_zeroed: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && udp_csum_byte_in && insertion_enable && ptp_event_in && ts_have && ipv4_in
        && !layer2_in && !checksum_correction_select && !fcs_byte_in |=> mac_data_out == 8'h00)
        else $error("UDP checksum byte not zeroed");

    a_fcs_corrupt: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && fcs_byte_in && udp_csum_err_in && csum_apply && !checksum_correction_select
        |=> mac_data_out == ~$past(rx_data_in))
        else $error("CRC byte not corrupted on checksum error");

    a_corr_placed: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && corr_hi && !udp_csum_err_in ##1 rx_valid_in && corr_lo && !udp_csum_err_in
        |=> mac_data_out == $past(corr_good[7:0]) && $past(mac_data_out) == $past(corr_good[15:8], 2))
        else $error("checksum fix not placed after message");

    a_corr_spoiled: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && corr_lo && udp_csum_err_in |=> mac_data_out[0] != $past(corr_good[0]))
        else $error("bad checksum not preserved in fix");

    a_sec_gated: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && !seconds_insert_enable && !ins_ns && !zero_csum && !fcs_bad && !corr_hi && !corr_lo
        |=> mac_data_out == $past(rx_data_in)) else $error("seconds written while off");

    a_disabled_pass: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && !insertion_enable |=> mac_data_out == $past(rx_data_in))
        else $error("byte altered while insertion disabled");

    a_ns_msb_first: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && ins_frame && !append_mode && in_msg_now && cur_pos == ns_off8 && !fcs_byte_in
        && !udp_csum_byte_in |=> mac_data_out == $past(ts_ns_q[31:24]))
        else $error("in-place nanoseconds not MSB first at offset");

    a_ns_append: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && ins_frame && append_mode && after_now && after_cnt == ns_off8 && !fcs_byte_in
        |=> mac_data_out == $past(ts_ns_q[31:24]))
        else $error("appended nanoseconds misplaced");

    a_sec_append: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_valid_in && ins_frame && append_mode && after_now && seconds_insert_enable && !fcs_byte_in
        && after_cnt == ns_off8 + 8'h04 + {2'b00, sec_field_offset} && seconds_insert_length == 2'b11
        |=> mac_data_out == $past(ts_sec_q[31:24]))
        else $error("appended seconds misplaced");

    a_readout_hidden: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        insertion_enable && $stable(insertion_enable) |-> !ts_readout_valid_out)
        else $error("timestamp offered for readout during insertion");

endmodule : rti_rx_insertion_enable

// file: dv/rti_mac_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// MAC receive side: takes every forwarded byte
// ----------------------------------------------------------------
module rti_mac_model (
    input wire logic mclk_in,
    input wire logic mac_valid_in,
    input wire logic [7:0] mac_data_in,
    input wire logic mac_last_in,
    input wire logic readout_in
);
    logic [7:0] got [$];
    int n_readout = 0;
    int last_at = 0;
    // The receive interface has no back-pressure, so nothing can stall here
    always @(posedge mclk_in) begin
        if (mac_valid_in) got.push_back(mac_data_in);
        // Only the first end marker counts, so an early one shows up as a short frame
        if (mac_valid_in && mac_last_in && last_at == 0) last_at = got.size();
        if (readout_in) n_readout++;
    end
endmodule : rti_mac_model

// file: dv/testbench.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Stimulus, expectations and verdict
// ----------------------------------------------------------------
module testbench;
    logic mclk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [7:0] avs_address_in, rx_data_in, mac_data_out;
    logic [31:0] avs_writedata_in, avs_readdata_out, ts_ns_in, ts_sec_in, q;
    logic [3:0] avs_byteenable_in;
    logic rx_valid_in, rx_last_in, msg_start_in, msg_end_in, udp_csum_byte_in, fcs_byte_in;
    logic ptp_event_in, ipv4_in, layer2_in, udp_csum_err_in, ts_valid_in;
    logic mac_valid_out, mac_last_out, ts_readout_valid_out;
    logic [15:0] corr;
    int n_mismatch = 0;
    int checks_done = 0;
    int n;
    // Rows: {append, insert, cfg[15:0]}; frames are Layer 2 so checksum logic stays idle
    logic [17:0] rows [8] = '{18'h0_7fff, 18'h1_0080, 18'h1_4008, 18'h1_510a,
                              18'h1_610a, 18'h1_700c, 18'h3_5041, 18'h3_7000};

    rti_rx_insertion_enable u_dut (.*);
    rti_mac_model u_mac (.mclk_in(mclk_in), .mac_valid_in(mac_valid_out), .mac_data_in(mac_data_out),
        .mac_last_in(mac_last_out), .readout_in(ts_readout_valid_out));

    always #20 mclk_in = ~mclk_in;

    // Bytes 18 and 19 are the spare UDP bytes and arrive as zero
    function automatic logic [7:0] val(input int i);
        return (i == 18 || i == 19) ? 8'h00 : 8'(i + 16);
    endfunction : val

    // Message starts at byte 2; ns wins where the two windows overlap
    function automatic logic [7:0] exp_b(input logic [17:0] c, input int i);
        int rel, nb, sb, ln;
        rel = i - 2;
        ln = int'(c[13:12]);
        nb = c[17] ? 16 + int'(c[11:6]) : int'(c[11:6]);
        sb = c[17] ? nb + 4 + int'(c[5:0]) : int'(c[5:0]);
        if (c[16] && rel >= nb && rel < nb + 4) return 8'(ts_ns_in >> (8 * (nb + 3 - rel)));
        if (c[16] && c[14] && rel >= sb && rel <= sb + ln) return 8'(ts_sec_in >> (8 * (sb + ln - rel)));
        return val(i);
    endfunction : exp_b

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        {avs_read_in, avs_write_in} <= 2'h0;
        // One idle edge keeps a following call from driving the same signals in this time step
        @(posedge mclk_in);
    endtask : bus

    // Thirty bytes: 2 header, 16 message, 8 tail, 4 FCS
    task automatic frame(input logic v4, input logic err);
        ipv4_in <= v4;
        layer2_in <= !v4;
        udp_csum_err_in <= err;
        ts_valid_in <= 1'b1; // Stamp lands before the checksum bytes that depend on it
        u_mac.got.delete();
        u_mac.last_at = 0;
        @(posedge mclk_in);
        for (int i = 0; i < 30; i++) begin
            rx_data_in <= val(i);
            {rx_valid_in, rx_last_in, msg_start_in, msg_end_in, udp_csum_byte_in, fcs_byte_in, ts_valid_in}
                <= {1'b1, i == 29, i == 2, i == 17, i < 2, i >= 26, 1'b0};
            @(posedge mclk_in);
        end
        {rx_valid_in, rx_last_in, msg_start_in, msg_end_in, udp_csum_byte_in, fcs_byte_in, ts_valid_in} <= 7'h00;
        repeat (3) @(posedge mclk_in);
    endtask : frame

    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // Watchdog well past the roughly five hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        {mclk_in, rst_n_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
        {rx_valid_in, rx_data_in, rx_last_in, msg_start_in, msg_end_in, udp_csum_byte_in} = '0;
        {fcs_byte_in, ipv4_in, layer2_in, udp_csum_err_in, ts_valid_in} = '0;
        avs_byteenable_in = 4'hf;
        ptp_event_in = 1'b1;
        ts_ns_in = 32'h1234_5678;
        ts_sec_in = 32'ha1b2_c3d4;
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        bus(1'b0, 8'h74, 32'h0000_0000);
        chk("cfg_reset", 32'h0000_0000, q);
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, q);
        foreach (rows[r]) begin
            bus(1'b1, 8'h74, {14'h0000, rows[r]});
            n = u_mac.n_readout;
            frame(1'b0, 1'b0);
            chk("length", 32'd30, u_mac.got.size());
            chk("last", 32'd30, u_mac.last_at);
            for (int i = 0; i < 30; i++) chk("byte", exp_b(rows[r], i), u_mac.got[i]);
            chk("readout", 32'(!rows[r][16]), u_mac.n_readout - n);
        end
        bus(1'b0, 8'h74, 32'h0000_0000);
        chk("cfg_read", 32'h0000_7000, q);
        // IPv4 with correction off: checksum zeroed, FCS spoilt on a bad checksum
        bus(1'b1, 8'h74, 32'h0001_0080);
        frame(1'b1, 1'b0);
        chk("csum_zero", 32'h0000_0000, {u_mac.got[0], u_mac.got[1]});
        chk("fcs_kept", 32'(val(29)), u_mac.got[29]);
        frame(1'b1, 1'b1);
        chk("fcs_bad", ~32'h2a2b_2c2d, {u_mac.got[26], u_mac.got[27], u_mac.got[28], u_mac.got[29]});
        // Correction on, only because the two spare bytes are present
        bus(1'b1, 8'h74, 32'h0001_8080);
        frame(1'b1, 1'b0);
        chk("csum_kept", {val(0), val(1)}, {u_mac.got[0], u_mac.got[1]});
        corr = {u_mac.got[18], u_mac.got[19]};
        frame(1'b1, 1'b1);
        chk("corr_err", 32'h0000_0001, corr ^ {u_mac.got[18], u_mac.got[19]});
        // Old words 1415 1617, new 1234 5678: fix is old minus new in ones' complement
        chk("corr", 32'h0000_c17f, corr);
        // Seven stamped rows plus four stamped IPv4 frames
        bus(1'b0, 8'h80, 32'h0000_0000);
        chk("stamped", 32'd11, q);
        // Reset in mid-run returns config and control to pass-through
        rst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        bus(1'b0, 8'h74, 32'h0000_0000);
        chk("cfg_after_reset", 32'h0000_0000, q);
        frame(1'b1, 1'b1);
        chk("fcs_after_reset", 32'(val(29)), u_mac.got[29]);
        give_verdict();
    end
endmodule : testbench
